// File: clock_source_routing_consts.vh
// Register map, field positions, reset values and limits of the clock routing block
`ifndef CLOCK_SOURCE_ROUTING_CONSTS_VH
`define CLOCK_SOURCE_ROUTING_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_PLL_POWER_POLARITY 10'h010
`define IDX_OSC_CALIBRATION    10'h018
`define IDX_PRE_DIVIDER_RATIO  10'h1e0
`define IDX_SOURCE_PATH        10'h1e1
`define IDX_CONFIG_TRANSFER    10'h232
`define IDX_ROUTING_STATUS     10'h233

// Field positions
`define POS_PLL_POWER_LSB      0
`define POS_PLL_POWER_MSB      1
`define POS_PFD_POLARITY       7
`define POS_CAL_START          0
`define POS_RATIO_LSB          0
`define POS_RATIO_MSB          2
`define POS_DIV_BYPASS         0
`define POS_SOURCE_SELECT      1

// Reset values
`define RST_PLL_POWER_POLARITY 8'h01
`define RST_OSC_CALIBRATION    8'h00
`define RST_PRE_DIVIDER_RATIO  8'h02
`define RST_SOURCE_PATH        8'h00

// Codes
`define PLL_POWER_NORMAL       2'h0
`define PLL_POWER_DOWN         2'h1
`define TRANSFER_COMMAND       8'h01
`define RATIO_CODE_DIV2        3'h0
`define RATIO_CODE_DIV6        3'h4
`define RATIO_MIN              3'h2

// Frequency limits in MHz
`define EXT_CLK_MAX_MHZ        2400
`define CHANNEL_DIV_MAX_MHZ    1600

`endif

// File: pre_divider.v
// Pre-divider between the selected clock source and the distribution section
`timescale 1ns/100ps
`include "clock_source_routing_consts.vh"

module pre_divider (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Control
    input  wire [2:0] ratioCode,
    input  wire       bypass,
    // Source and distribution ticks
    input  wire       srcTick,
    output reg        distTick_q
);

    reg  [2:0] count_q;
    wire [2:0] ratio;
    wire [2:0] terminal;

    // Codes above divide-by-6 clamp to 6; the ratio never drops below 2
    assign ratio = (ratioCode > `RATIO_CODE_DIV6) ? 3'h6
                 : ratioCode + `RATIO_MIN;
    assign terminal = ratio - 3'h1;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q    <= 3'h0;
            distTick_q <= 1'b0;
        end else if (bypass) begin
            count_q    <= 3'h0;
            distTick_q <= srcTick;
        end else if (srcTick) begin
            if (count_q >= terminal) begin
                count_q    <= 3'h0;
                distTick_q <= 1'b1;
            end else begin
                count_q    <= count_q + 3'h1;
                distTick_q <= 1'b0;
            end
        end else begin
            distTick_q <= 1'b0;
        end
    end

endmodule // pre_divider

// File: osc_calibration.v
// Oscillator calibration sequencer
`timescale 1ns/100ps

module osc_calibration #(
    parameter CAL_CYCLES = 1000
) (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Control
    input  wire start,
    input  wire calReset,
    // Status
    output reg  busy_q,
    output reg  done_q
);

    reg [31:0] count_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 32'h0000_0000;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else if (start) begin
            count_q <= CAL_CYCLES - 1;
            busy_q  <= 1'b1;
            done_q  <= 1'b0;
        end else if (calReset) begin
            count_q <= 32'h0000_0000;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else if (busy_q) begin
            if (count_q == 32'h0000_0000) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else begin
                count_q <= count_q - 32'h0000_0001;
            end
        end
    end

endmodule // osc_calibration

// File: clock_source_routing_config.v
// Staged clock source and path configuration with Avalon-MM register access
//
// Summary of operation
// - Reset: PLL off, divide-by-4, divider used, external.
// - External clock to 2400 MHz through divider.
// - Pre-divider ratio is never below two.
// - Three-bit code selects ratio 2 through 6.
// - Settings apply only after transfer register gets 0x01.
// - Power code 01 powers down, 00 runs.
// - Source bit one picks oscillator, zero external.
// - Bypass bit one skips the pre-divider.
// - Polarity bit zero positive, one negative sense.
// - External source keeps internal oscillator powered off.
// - Transfer that changes the active calibration bit from 0 to 1 starts oscillator calibration.
`timescale 1ns/100ps
`include "clock_source_routing_consts.vh"

module clock_source_routing_config #(
    parameter CAL_CYCLES = 1000
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Avalon-MM slave
    input  wire [9:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // Source clock ticks
    input  wire        extClkTick,
    input  wire        oscTick,
    // Distribution path
    output wire        distTick,
    // Active configuration
    output reg  [1:0]  pllPowerCode,
    output reg         pllPowerDown,
    output reg         pfdPolarityNeg,
    output reg  [2:0]  preDivCode,
    output reg         dividerBypass,
    output reg         sourceIsOsc,
    output reg         oscPowerOn,
    // Calibration status
    output wire        calBusy,
    output wire        calDone
);

    // Bus handshake states
    localparam [1:0] BUS_IDLE = 2'b01;
    localparam [1:0] BUS_ACK  = 2'b10;

    // Reset words held as named constants so their fields can be sliced
    localparam [7:0] RST_PLL_WORD   = `RST_PLL_POWER_POLARITY;
    localparam [7:0] RST_RATIO_WORD = `RST_PRE_DIVIDER_RATIO;

    reg  [1:0] busState_q;
    reg  [1:0] busState_d;

    // Staged copies seen by software
    reg  [7:0] pllCtl_q;
    reg  [7:0] calCtl_q;
    reg  [7:0] ratioCtl_q;
    reg  [7:0] pathCtl_q;

    // Active copy of the calibration bit
    reg        actCal_q;

    // Pulses for one cycle when a transfer is taken
    reg        transfer;
    reg        calStart;
    reg        calClear;

    wire       writeTaken;
    wire       readStart;
    reg [31:0] readValue;

    wire       selTick;
    wire       newCal;
    wire       newSource;

    // A request is answered one cycle after it is first seen
    assign writeTaken = write && (busState_q == BUS_ACK);
    assign readStart  = read && (busState_q == BUS_IDLE);

    always @* begin
        case (busState_q)
            BUS_IDLE: begin
                if (read || write) begin
                    busState_d = BUS_ACK;
                end else begin
                    busState_d = BUS_IDLE;
                end
            end
            BUS_ACK: begin
                busState_d = BUS_IDLE;
            end
            default: begin
                busState_d = BUS_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busState_q  <= BUS_IDLE;
            waitrequest <= 1'b1;
        end else begin
            busState_q  <= busState_d;
            waitrequest <= (busState_d != BUS_ACK);
        end
    end

    // Staged registers take writes; nothing reaches the hardware yet
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pllCtl_q   <= `RST_PLL_POWER_POLARITY;
            calCtl_q   <= `RST_OSC_CALIBRATION;
            ratioCtl_q <= `RST_PRE_DIVIDER_RATIO;
            pathCtl_q  <= `RST_SOURCE_PATH;
        end else if (writeTaken) begin
            case (address)
                `IDX_PLL_POWER_POLARITY: begin
                    pllCtl_q <= writedata[7:0];
                end
                `IDX_OSC_CALIBRATION: begin
                    calCtl_q <= writedata[7:0];
                end
                `IDX_PRE_DIVIDER_RATIO: begin
                    ratioCtl_q <= writedata[7:0];
                end
                `IDX_SOURCE_PATH: begin
                    pathCtl_q <= writedata[7:0];
                end
                default: begin
                    pllCtl_q <= pllCtl_q;
                end
            endcase
        end
    end

    // Only the exact command value triggers a transfer
    always @* begin
        transfer = writeTaken
                && (address == `IDX_CONFIG_TRANSFER)
                && (writedata[7:0] == `TRANSFER_COMMAND);
    end

    assign newCal    = calCtl_q[`POS_CAL_START];
    assign newSource = pathCtl_q[`POS_SOURCE_SELECT];

    // Calibration runs only on a 0 to 1 change of the active bit,
    // so a repeat needs the bit cleared by an earlier transfer
    always @* begin
        calStart = transfer && newCal && !actCal_q;
        calClear = transfer && !newCal;
    end

    // Every active field loads on the same edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pllPowerCode   <= RST_PLL_WORD[`POS_PLL_POWER_MSB:`POS_PLL_POWER_LSB];
            pllPowerDown   <= 1'b1;
            pfdPolarityNeg <= 1'b0;
            preDivCode     <= RST_RATIO_WORD[`POS_RATIO_MSB:`POS_RATIO_LSB];
            dividerBypass  <= 1'b0;
            sourceIsOsc    <= 1'b0;
            oscPowerOn     <= 1'b0;
            actCal_q       <= 1'b0;
        end else if (transfer) begin
            pllPowerCode   <= pllCtl_q[`POS_PLL_POWER_MSB:`POS_PLL_POWER_LSB];
            pllPowerDown   <= (pllCtl_q[`POS_PLL_POWER_MSB:`POS_PLL_POWER_LSB]
                               != `PLL_POWER_NORMAL);
            pfdPolarityNeg <= pllCtl_q[`POS_PFD_POLARITY];
            preDivCode     <= ratioCtl_q[`POS_RATIO_MSB:`POS_RATIO_LSB];
            dividerBypass  <= pathCtl_q[`POS_DIV_BYPASS];
            sourceIsOsc    <= newSource;
            oscPowerOn     <= newSource;
            actCal_q       <= newCal;
        end
    end

    // The oscillator tick is ignored whenever it is powered off
    assign selTick = sourceIsOsc ? (oscTick && oscPowerOn)
                                 : extClkTick;

    pre_divider u_preDivider (
        .clk        (clk),
        .rst_n      (rst_n),
        .ratioCode  (preDivCode),
        .bypass     (dividerBypass),
        .srcTick    (selTick),
        .distTick_q (distTick)
    );

    osc_calibration #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_oscCalibration (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (calStart),
        .calReset (calClear),
        .busy_q   (calBusy),
        .done_q   (calDone)
    );

    // Staged values read back; status shows the live state
    always @* begin
        case (address)
            `IDX_PLL_POWER_POLARITY: begin
                readValue = {24'h00_0000, pllCtl_q};
            end
            `IDX_OSC_CALIBRATION: begin
                readValue = {24'h00_0000, calCtl_q};
            end
            `IDX_PRE_DIVIDER_RATIO: begin
                readValue = {24'h00_0000, ratioCtl_q};
            end
            `IDX_SOURCE_PATH: begin
                readValue = {24'h00_0000, pathCtl_q};
            end
            `IDX_ROUTING_STATUS: begin
                readValue = {24'h00_0000,
                             pllPowerDown,
                             pfdPolarityNeg,
                             actCal_q,
                             sourceIsOsc,
                             dividerBypass,
                             oscPowerOn,
                             calDone,
                             calBusy};
            end
            default: begin
                readValue = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (readStart) begin
            readdata <= readValue;
        end
    end

endmodule // clock_source_routing_config

// File: clock_source_routing_config_properties.sv
// Concurrent checks on the ports of the clock routing block
`timescale 1ns/100ps
module clock_source_routing_config_properties #(
    parameter CAL_CYCLES = 1000
) (
    // Clock, reset and bus
    input wire        clk,
    input wire        rst_n,
    input wire [9:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire        waitrequest,
    // Ticks and configuration
    input wire        extClkTick,
    input wire        oscTick,
    input wire        distTick,
    input wire [1:0]  pllPowerCode,
    input wire        pllPowerDown,
    input wire        pfdPolarityNeg,
    input wire [2:0]  preDivCode,
    input wire        dividerBypass,
    input wire        sourceIsOsc,
    input wire        oscPowerOn,
    input wire        calBusy,
    input wire        calDone
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire       xfer = write && !waitrequest && address == 10'h232 && writedata[7:0] == 8'h01;
    wire [8:0] cfg  = {pllPowerCode, pfdPolarityNeg, preDivCode, dividerBypass, sourceIsOsc, oscPowerOn};
    reg [15:0] busyCnt_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) busyCnt_q <= 16'h0000;
        else busyCnt_q <= calBusy ? busyCnt_q + 16'h0001 : 16'h0000;
    end
    sequence s_answer;
        ##1 !waitrequest ##1 waitrequest;
    endsequence
    a_bus_answer: assert property ((read || write) && waitrequest |-> s_answer)
        else $error("bus answer not one cycle long");
    a_reset_state: assert property ($rose(rst_n) |-> cfg == 9'h090 && pllPowerDown)
        else $error("wrong state after reset");
    a_hold_staged: assert property (!xfer |=> $stable(cfg))
        else $error("active setting changed without transfer");
    a_power_flag: assert property (pllPowerDown == (pllPowerCode != 2'h0))
        else $error("power-down flag disagrees with code");
    a_osc_power: assert property (oscPowerOn == sourceIsOsc)
        else $error("oscillator power disagrees with source");
    a_bypass_pass: assert property (dividerBypass && (sourceIsOsc ? oscTick : extClkTick) |=> distTick)
        else $error("bypassed tick not passed");
    a_ratio_floor: assert property (!dividerBypass && $stable(dividerBypass) && distTick |=> !distTick)
        else $error("divided ticks closer than two");
    a_cal_start: assert property ($rose(calBusy) |-> $past(xfer))
        else $error("calibration began without transfer");
    a_cal_length: assert property ($fell(calBusy) && calDone |-> busyCnt_q == CAL_CYCLES)
        else $error("calibration length wrong");
endmodule // clock_source_routing_config_properties

bind clock_source_routing_config clock_source_routing_config_properties #(.CAL_CYCLES(CAL_CYCLES)) u_props (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .extClkTick(extClkTick), .oscTick(oscTick),
    .distTick(distTick), .pllPowerCode(pllPowerCode), .pllPowerDown(pllPowerDown),
    .pfdPolarityNeg(pfdPolarityNeg), .preDivCode(preDivCode), .dividerBypass(dividerBypass),
    .sourceIsOsc(sourceIsOsc), .oscPowerOn(oscPowerOn), .calBusy(calBusy), .calDone(calDone));

// File: host_model.sv
// Host that programs the routing registers over Avalon-MM
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire        clk,
    // Avalon-MM master
    output logic [9:0]  address,
    output logic        read,
    output logic        write,
    output logic [31:0] writedata,
    input  wire  [31:0] readdata,
    input  wire         waitrequest
);
    initial begin
        address = 10'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
    end
    // Request held until waitrequest is seen low; no latency assumed
    task access(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h00_0000, d};
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule // host_model

// File: clock_source_routing_config_bench.sv
// Register-level tests of the clock routing block
`timescale 1ns/100ps
module clock_source_routing_config_bench;
    logic clk = 1'b0, rstN = 1'b0, extClkTick = 1'b0, oscTick = 1'b0;
    wire [9:0]  address;
    wire        read, write, waitrequest, distTick, pllPowerDown, pfdPolarityNeg;
    wire        dividerBypass, sourceIsOsc, oscPowerOn, calBusy, calDone;
    wire [31:0] writedata, readdata;
    wire [1:0]  pllPowerCode;
    wire [2:0]  preDivCode;
    wire [9:0]  cfg = {pllPowerCode, pllPowerDown, pfdPolarityNeg, preDivCode, dividerBypass, sourceIsOsc, oscPowerOn};
    int nFail = 0, checkCount = 0, cycles = 0, cnt;
    always #10 clk = ~clk;
    host_model u_host_model (.clk(clk), .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    clock_source_routing_config #(.CAL_CYCLES(10)) u_clock_source_routing_config (.clk(clk), .rst_n(rstN),
        .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .extClkTick(extClkTick), .oscTick(oscTick), .distTick(distTick),
        .pllPowerCode(pllPowerCode), .pllPowerDown(pllPowerDown), .pfdPolarityNeg(pfdPolarityNeg),
        .preDivCode(preDivCode), .dividerBypass(dividerBypass), .sourceIsOsc(sourceIsOsc),
        .oscPowerOn(oscPowerOn), .calBusy(calBusy), .calDone(calDone));
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        u_host_model.access(1'b1, a, d, q);
    endtask
    task rd(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        u_host_model.access(1'b0, a, 8'h00, q);
        chk("readdata", exp, q);
    endtask
    // Outputs load at the executing edge, so one more edge before looking
    task xfer;
        wr(10'h232, 8'h01);
        @(posedge clk);
    endtask
    // Window of 60 ticks is a multiple of every ratio, so phase does not matter
    task span(input int exp);
        repeat (12) @(posedge clk);
        cnt = 0;
        repeat (60) begin
            @(posedge clk);
            if (distTick === 1'b1) cnt++;
        end
        chk("distTick count", exp, cnt);
    endtask
    task cal(input int exp);
        wr(10'h232, 8'h01);
        cnt = 0;
        repeat (30) begin
            @(posedge clk);
            if (calBusy === 1'b1) cnt++;
        end
        chk("calBusy cycles", exp, cnt);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            close_out;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rstN <= 1'b1;
        extClkTick <= 1'b1;
        @(posedge clk);
        chk("config", 10'h190, cfg);
        rd(10'h010, 32'h0000_0001);
        rd(10'h1e0, 32'h0000_0002);
        rd(10'h1e1, 32'h0000_0000);
        rd(10'h005, 32'h0000_0000);
        rd(10'h232, 32'h0000_0000);
        span(15);
        $display("test reset defaults done");
        wr(10'h010, 8'h80);
        wr(10'h1e0, 8'h04);
        wr(10'h1e1, 8'h01);
        wr(10'h232, 8'h03);
        @(posedge clk);
        chk("config", 10'h190, cfg);
        xfer;
        chk("config", 10'h064, cfg);
        span(60);
        $display("test staged transfer done");
        wr(10'h1e1, 8'h03);
        xfer;
        chk("config", 10'h067, cfg);
        span(0);
        oscTick <= 1'b1;
        span(60);
        $display("test source select done");
        for (int c = 0; c < 6; c++) begin
            wr(10'h1e0, (c == 5) ? 8'h07 : 8'(c));
            wr(10'h1e1, 8'h00);
            xfer;
            span(60 / (((c > 4) ? 4 : c) + 2));
        end
        $display("test divider ratios done");
        wr(10'h018, 8'h01);
        cal(10);
        chk("calDone", 1, calDone);
        cal(0);
        wr(10'h018, 8'h00);
        xfer;
        chk("calDone", 0, calDone);
        wr(10'h018, 8'h01);
        cal(10);
        rd(10'h233, 32'h0000_0062);
        $display("test calibration done");
        rstN <= 1'b0;
        repeat (2) @(posedge clk);
        rstN <= 1'b1;
        @(posedge clk);
        chk("config", 10'h190, cfg);
        $display("test second reset done");
        close_out;
    end
endmodule // clock_source_routing_config_bench
